//--- handoff_pkg.sv
// handoff_pkg: shared constants and types for the local bus handoff block
// assumes: single 125 MHz clock domain, synchronous active-low reset
package handoff_pkg;

    // -------------------------------------------------------------
    // bus widths
    // -------------------------------------------------------------
    localparam int UPPER_W = 5;
    localparam int LOWER_W = 2;

    // -------------------------------------------------------------
    // transfer-mode error codes seen on the backplane ack cycle
    // -------------------------------------------------------------
    localparam logic [1:0] TM_OK = 2'h0;

    // -------------------------------------------------------------
    // timing: hold of bus_fault_n after local_addr_valid_n rises
    // -------------------------------------------------------------
    localparam int FAULT_HOLD_NS  = 40;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int FAULT_HOLD_CYC =
        (FAULT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FAULT_HOLD_CNT = 4'(FAULT_HOLD_CYC);

    // -------------------------------------------------------------
    // reset values of pin drivers (all inactive high)
    // -------------------------------------------------------------
    localparam logic PIN_IDLE = 1'h1;

    // local master sequencer
    typedef enum logic [4:0] {
        M_IDLE  = 5'h01,
        M_REQ   = 5'h02,
        M_TAKE  = 5'h04,
        M_CYCLE = 5'h08,
        M_DONE  = 5'h10
    } mst_state_t;

    // relinquish-and-retry sequencer
    typedef enum logic [3:0] {
        F_IDLE  = 4'h1,
        F_BOTH  = 4'h2,
        F_HOLD  = 4'h4,
        F_WAIT  = 4'h8
    } flt_state_t;

endpackage

//--- sync_if.sv
// sync_if: synchronised pin levels passed from the input stage to the core
// assumes: both ends on ref_clk
`timescale 1ns/1ps
interface sync_if;
    logic       as_n;
    logic       grant_n;
    logic       done_n;
    logic [4:0] upper;
    logic [1:0] lower;
    modport src (output as_n, grant_n, done_n, upper, lower);
    modport dst (input  as_n, grant_n, done_n, upper, lower);
endinterface

//--- pin_sync.sv
// pin_sync: two-flop synchronisers for every asynchronous local pin except the data bus
// assumes: pins change freely relative to ref_clk
`timescale 1ns/1ps
module pin_sync
    import handoff_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // raw pins
    input  wire logic               as_pin_n,
    input  wire logic               grant_pin_n,
    input  wire logic               done_pin_n,
    input  wire logic [UPPER_W-1:0] upper_pin,
    input  wire logic [LOWER_W-1:0] lower_pin,
    // synchronised levels
    sync_if.src                     so
);
    localparam int W = 3 + UPPER_W + LOWER_W;

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;

    // first stage feeds only the second stage
    always_comb begin
        s1_nxt = {as_pin_n, grant_pin_n, done_pin_n, upper_pin, lower_pin};
        s2_nxt = s1_r;
    end

    // idle-high controls after reset, addresses zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s1_r <= {3'h7, {(UPPER_W+LOWER_W){1'b0}}};
            s2_r <= {3'h7, {(UPPER_W+LOWER_W){1'b0}}};
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign so.as_n    = s2_r[W-1];
    assign so.grant_n = s2_r[W-2];
    assign so.done_n  = s2_r[W-3];
    assign so.upper   = s2_r[UPPER_W+LOWER_W-1:LOWER_W];
    assign so.lower   = s2_r[LOWER_W-1:0];

endmodule // pin_sync

//--- local_bus_master_handoff.sv
// local_bus_master_handoff: local-bus side of the backplane bridge
// assumes: backplane-side logic on ref_clk supplies requests, tm bits
// and the atten-null indication; local pins arrive asynchronously
`timescale 1ns/1ps

module local_bus_master_handoff
    import handoff_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // local address pins, split into in/out/enable
    input  wire logic [UPPER_W-1:0] upper_local_addr_i,
    output logic      [UPPER_W-1:0] upper_local_addr_o,
    output logic                    upper_local_addr_oe,
    input  wire logic [LOWER_W-1:0] lower_local_addr_i,
    output logic      [LOWER_W-1:0] lower_local_addr_o,
    output logic                    lower_local_addr_oe,
    // address strobe pin
    input  wire logic               local_addr_valid_n_i,
    output logic                    local_addr_valid_n_o,
    output logic                    local_addr_valid_n_oe,
    // arbitration pins
    output logic                    req_out_n,
    input  wire logic               grant_in_n,
    output logic                    mastership_taken_n,
    // cycle end and fault pins
    input  wire logic               transfer_done_n,
    input  wire logic [7:0]         local_data_i,
    output logic                    bus_fault_n,
    output logic                    retry_hold_n,
    // backplane side: incoming access to serve locally
    input  wire logic               bp_in_req,
    input  wire logic [UPPER_W-1:0] bp_in_upper,
    input  wire logic [LOWER_W-1:0] bp_in_lower,
    input  wire logic               bp_in_read,
    output logic                    bp_in_done,
    output logic      [7:0]         bp_in_rdata,
    // backplane side: outgoing access of the processor
    input  wire logic               bp_out_busy,
    input  wire logic               bp_ack_cycle,
    input  wire logic [1:0]         bp_tm,
    input  wire logic               bp_atten_null,
    // external local master request
    input  wire logic               ext_req,
    // processor register access qualifier and sampled address
    output logic                    reg_sel,
    output logic      [UPPER_W-1:0] reg_upper,
    output logic      [LOWER_W-1:0] reg_lower
);
    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    sync_if sy ();

    pin_sync u_sync (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .as_pin_n    (local_addr_valid_n_i),
        .grant_pin_n (grant_in_n),
        .done_pin_n  (transfer_done_n),
        .upper_pin   (upper_local_addr_i),
        .lower_pin   (lower_local_addr_i),
        .so          (sy.src)
    );

    // -------------------------------------------------------------
    // local master sequencer
    // -------------------------------------------------------------
    mst_state_t         m_r, m_nxt;
    logic [UPPER_W-1:0] up_r, up_nxt;
    logic [LOWER_W-1:0] lo_r, lo_nxt;
    logic               rd_r, rd_nxt;
    logic               drv_r, drv_nxt;
    logic               as_r, as_nxt;
    logic               req_r, req_nxt;
    logic               tkn_r, tkn_nxt;
    logic               dn_r, dn_nxt;
    logic [7:0]         dat_r, dat_nxt;
    logic [7:0]         dat_s1_r, dat_s2_r;

    // data bus passes two flops, as every asynchronous pin does
    always_ff @(posedge ref_clk) begin
        if (!rstn) {dat_s2_r, dat_s1_r} <= 16'h0000;
        else       {dat_s2_r, dat_s1_r} <= {dat_s1_r, local_data_i};
    end

    // next-state of the master sequencer
    always_comb begin
        m_nxt   = m_r;
        up_nxt  = up_r;
        lo_nxt  = lo_r;
        rd_nxt  = rd_r;
        drv_nxt = drv_r;
        as_nxt  = as_r;
        req_nxt = req_r;
        tkn_nxt = tkn_r;
        dn_nxt  = 1'b0;
        dat_nxt = dat_r;
        unique case (m_r)
            M_IDLE: begin
                req_nxt = !(bp_in_req || ext_req);
                if (bp_in_req) begin
                    up_nxt = bp_in_upper;
                    lo_nxt = bp_in_lower;
                    rd_nxt = bp_in_read;
                    m_nxt  = M_REQ;
                end
            end
            M_REQ: begin
                req_nxt = 1'b0;
                // wait for grant low, and for strobe idle
                if (!sy.grant_n && sy.as_n) begin
                    // announce that we own the bus
                    tkn_nxt = 1'b0;
                    m_nxt   = M_TAKE;
                end
            end
            M_TAKE: begin
                // own the address lines once taken is out
                drv_nxt = 1'b1;
                m_nxt   = M_CYCLE;
            end
            M_CYCLE: begin
                // strobe one cycle after address is stable
                as_nxt = 1'b0;
                if (!as_r && !sy.done_n) begin
                    if (rd_r) dat_nxt = dat_s2_r;
                    dn_nxt = 1'b1;
                    m_nxt  = M_DONE;
                end
            end
            M_DONE: begin
                as_nxt  = 1'b1;
                drv_nxt = 1'b0;
                tkn_nxt = 1'b1;
                req_nxt = !ext_req;
                m_nxt   = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            m_r   <= M_IDLE;
            up_r  <= '0;
            lo_r  <= '0;
            rd_r  <= 1'b0;
            drv_r <= 1'b0;
            as_r  <= PIN_IDLE;
            req_r <= PIN_IDLE;
            tkn_r <= PIN_IDLE;
            dn_r  <= 1'b0;
            dat_r <= 8'h00;
        end else begin
            m_r   <= m_nxt;
            up_r  <= up_nxt;
            lo_r  <= lo_nxt;
            rd_r  <= rd_nxt;
            drv_r <= drv_nxt;
            as_r  <= as_nxt;
            req_r <= req_nxt;
            tkn_r <= tkn_nxt;
            dn_r  <= dn_nxt;
            dat_r <= dat_nxt;
        end
    end

    // -------------------------------------------------------------
    // fault and relinquish-and-retry sequencer
    // -------------------------------------------------------------
    flt_state_t f_r, f_nxt;
    logic       flt_r, flt_nxt;
    logic       hold_r, hold_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       atn_r, atn_nxt;

    // early release of retry_hold_n risks a backplane lockup
    always_comb begin
        f_nxt    = f_r;
        flt_nxt  = flt_r;
        hold_nxt = hold_r;
        cnt_nxt  = cnt_r;
        atn_nxt  = atn_r || bp_atten_null;
        unique case (f_r)
            F_IDLE: begin
                atn_nxt = 1'b0;
                // incoming access wins over our outgoing one
                if (bp_in_req && bp_out_busy) begin
                    flt_nxt  = 1'b0;
                    hold_nxt = 1'b0;
                    f_nxt    = F_BOTH;
                end else if (bp_out_busy && bp_ack_cycle &&
                             bp_tm != TM_OK) begin
                    flt_nxt = 1'b0;
                    f_nxt   = F_WAIT;
                end
            end
            F_BOTH: begin
                // fault hold starts at processor strobe rise
                if (sy.as_n) begin
                    cnt_nxt = FAULT_HOLD_CNT;
                    f_nxt   = F_HOLD;
                end
            end
            F_HOLD: begin
                if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
                else               flt_nxt = 1'b1;
                if (atn_r || bp_atten_null) hold_nxt = 1'b1;
                if (cnt_r == 4'h0 && (hold_r || atn_r || bp_atten_null)) begin
                    f_nxt = F_IDLE;
                end
            end
            F_WAIT: begin
                // plain bus error ends with the processor strobe
                if (sy.as_n) begin
                    flt_nxt = 1'b1;
                    f_nxt   = F_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            f_r    <= F_IDLE;
            flt_r  <= PIN_IDLE;
            hold_r <= PIN_IDLE;
            cnt_r  <= 4'h0;
            atn_r  <= 1'b0;
        end else begin
            f_r    <= f_nxt;
            flt_r  <= flt_nxt;
            hold_r <= hold_nxt;
            cnt_r  <= cnt_nxt;
            atn_r  <= atn_nxt;
        end
    end

    // -------------------------------------------------------------
    // processor register access sampling
    // -------------------------------------------------------------
    logic               sel_r, sel_nxt;
    logic [UPPER_W-1:0] ru_r, ru_nxt;
    logic [LOWER_W-1:0] rl_r, rl_nxt;

    // strobe from the processor qualifies the address
    always_comb begin
        sel_nxt = !sy.as_n && !drv_r;
        ru_nxt  = sel_nxt ? sy.upper : ru_r;
        rl_nxt  = sel_nxt ? sy.lower : rl_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sel_r <= 1'b0;
            ru_r  <= '0;
            rl_r  <= '0;
        end else begin
            sel_r <= sel_nxt;
            ru_r  <= ru_nxt;
            rl_r  <= rl_nxt;
        end
    end

    // -------------------------------------------------------------
    // outputs, all straight from flops
    // -------------------------------------------------------------
    assign {upper_local_addr_o, lower_local_addr_o}   = {up_r, lo_r};
    assign {upper_local_addr_oe, lower_local_addr_oe} = {2{drv_r}};
    assign {local_addr_valid_n_o, local_addr_valid_n_oe} = {as_r, drv_r};
    assign {req_out_n, mastership_taken_n} = {req_r, tkn_r};
    assign {bus_fault_n, retry_hold_n}     = {flt_r, hold_r};
    assign {bp_in_done, bp_in_rdata}       = {dn_r, dat_r};
    assign {reg_sel, reg_upper, reg_lower} = {sel_r, ru_r, rl_r};

endmodule // local_bus_master_handoff

//--- handoff_asserts.sv
// handoff_asserts: port-level checks for local_bus_master_handoff
// assumes: bound to that module, ref_clk only, rstn sync active low
`timescale 1ns/1ps
module handoff_asserts
    import handoff_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rstn,
    // local pins
    input wire logic       upper_local_addr_oe,
    input wire logic       local_addr_valid_n_i,
    input wire logic       local_addr_valid_n_o,
    input wire logic       local_addr_valid_n_oe,
    input wire logic       req_out_n,
    input wire logic       grant_in_n,
    input wire logic       mastership_taken_n,
    input wire logic       transfer_done_n,
    input wire logic       bus_fault_n,
    input wire logic       retry_hold_n,
    // backplane side and external master
    input wire logic       bp_in_req,
    input wire logic       bp_in_done,
    input wire logic       bp_out_busy,
    input wire logic       bp_ack_cycle,
    input wire logic [1:0] bp_tm,
    input wire logic       bp_atten_null,
    input wire logic       ext_req
);
    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // atten-null seen since retry_hold_n fell; cleared once it lifts
    logic atten_seen_r;
    always_ff @(posedge ref_clk) begin
        atten_seen_r <= rstn && !retry_hold_n && (atten_seen_r || bp_atten_null);
    end

    req_bp_a: assert property ($rose(bp_in_req) |-> ##[1:2] !req_out_n)
        else $error("no request after incoming access");
    req_ext_a: assert property (ext_req |-> ##[1:3] !req_out_n)
        else $error("no request for external master");
    grant_first_a: assert property ($fell(mastership_taken_n) |->
        !$past(grant_in_n, 2)) else $error("bus taken without grant");
    drive_owned_a: assert property ((upper_local_addr_oe ||
        local_addr_valid_n_oe) |-> !mastership_taken_n)
        else $error("pins driven while not owner");
    strobe_addr_a: assert property ($fell(local_addr_valid_n_o) |->
        local_addr_valid_n_oe && $past(upper_local_addr_oe))
        else $error("strobe low before address driven");
    done_end_a: assert property ($fell(transfer_done_n) &&
        local_addr_valid_n_oe && !local_addr_valid_n_o |->
        ##3 bp_in_done ##1 !local_addr_valid_n_oe)
        else $error("cycle not ended on ack");
    error_fault_a: assert property (bp_out_busy && bp_ack_cycle &&
        bp_tm != TM_OK && bus_fault_n && retry_hold_n |=> !bus_fault_n)
        else $error("backplane error not reported");
    collide_both_a: assert property (bp_in_req && bp_out_busy &&
        bus_fault_n && retry_hold_n |=> !bus_fault_n && !retry_hold_n)
        else $error("collision not signalled on both lines");
    retry_atten_a: assert property ($rose(retry_hold_n) |->
        atten_seen_r) else $error("retry lifted before atten-null");
    fault_lift_a: assert property ($rose(local_addr_valid_n_i) &&
        !bus_fault_n |-> ##[1:12] bus_fault_n)
        else $error("fault held after strobe release");

    // main scenarios reached
    cover property (!bus_fault_n && !retry_hold_n);
    cover property (bp_in_done);
    cover property ($rose(retry_hold_n));
    cover property (!bus_fault_n && retry_hold_n);
endmodule // handoff_asserts

bind local_bus_master_handoff handoff_asserts handoff_asserts_i (
    .ref_clk, .rstn, .upper_local_addr_oe, .local_addr_valid_n_i,
    .local_addr_valid_n_o, .local_addr_valid_n_oe, .req_out_n, .grant_in_n,
    .mastership_taken_n, .transfer_done_n, .bus_fault_n, .retry_hold_n,
    .bp_in_req, .bp_in_done, .bp_out_busy, .bp_ack_cycle, .bp_tm,
    .bp_atten_null, .ext_req
);

//--- local_proc_model.sv
// local_proc_model: local processor arbiter and local memory responder
// assumes: the bench resolves shared pins and feeds their levels here
`timescale 1ns/1ps
module local_proc_model (
    // clock and pace
    input  wire logic       ref_clk,
    input  wire logic       slow,
    // levels seen on the local bus
    input  wire logic       req_out_n,
    input  wire logic       mastership_taken_n,
    input  wire logic       as_w,
    input  wire logic       ctl_oe,
    input  wire logic [4:0] up_w,
    input  wire logic [1:0] lo_w,
    // answers
    output logic            grant_in_n,
    output logic            transfer_done_n,
    output logic      [7:0] local_data_i
);
    logic [7:0] pat;
    int         gcnt;
    int         dcnt;

    // data from sampled address; stale lines wander meanwhile
    assign local_data_i = transfer_done_n ? pat : {up_w, lo_w, 1'b0} ^ 8'hA5;

    // answers change off the edge, like a real asynchronous part
    initial begin
        grant_in_n = 1'b1;
        transfer_done_n = 1'b1;
        pat = 8'h00;
    end
    always @(posedge ref_clk) begin
        #2;
        pat = pat + 8'h3B;
        // grant after request, withdrawn once taken
        if (req_out_n || !mastership_taken_n) begin
            gcnt = 0;
            grant_in_n = 1'b1;
        end else if (gcnt >= (slow ? 4 : 1)) grant_in_n = 1'b0;
        else gcnt++;
        if (as_w || !ctl_oe) begin
            dcnt = 0;
            transfer_done_n = 1'b1;
        end else if (dcnt >= (slow ? 3 : 0)) transfer_done_n = 1'b0;
        else dcnt++;
    end
endmodule // local_proc_model

//--- local_bus_master_handoff_tb.sv
// local_bus_master_handoff_tb: random and corner tests of the handoff
// assumes: local_proc_model answers; bench plays the processor master
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end \
end
module local_bus_master_handoff_tb;
    logic       ref_clk, rstn, slow, p_drv, p_as_n, as_w, ext_req, reg_sel;
    logic       upper_local_addr_oe, lower_local_addr_oe, req_out_n;
    logic       local_addr_valid_n_o, local_addr_valid_n_oe, grant_in_n;
    logic       mastership_taken_n, transfer_done_n, bus_fault_n;
    logic       retry_hold_n, bp_in_req, bp_in_read, bp_in_done;
    logic       bp_out_busy, bp_ack_cycle, bp_atten_null;
    logic [4:0] upper_local_addr_o, up_w, p_up, bp_in_upper, reg_upper;
    logic [1:0] lower_local_addr_o, lo_w, p_lo, bp_in_lower, reg_lower;
    logic [1:0] bp_tm;
    logic [7:0] local_data_i, bp_in_rdata, pat;
    logic [6:0] a7, drv_a;
    logic [3:0] idle4;
    logic [2:0] oe3;
    int         mismatches, check_count;

    // strobe has a pull-up; idle address lines wander
    assign as_w = local_addr_valid_n_oe ? local_addr_valid_n_o
                : p_drv ? p_as_n : 1'b1;
    assign up_w = upper_local_addr_oe ? upper_local_addr_o
                : p_drv ? p_up : pat[4:0];
    assign lo_w = lower_local_addr_oe ? lower_local_addr_o
                : p_drv ? p_lo : pat[6:5];
    assign a7 = {bp_in_upper, bp_in_lower};
    assign drv_a = {upper_local_addr_o, lower_local_addr_o};
    assign idle4 = {req_out_n, mastership_taken_n, bus_fault_n, retry_hold_n};
    assign oe3 = {local_addr_valid_n_oe, upper_local_addr_oe,
                  lower_local_addr_oe};

    local_bus_master_handoff local_bus_master_handoff_i (
        .ref_clk, .rstn, .upper_local_addr_i(up_w), .upper_local_addr_o,
        .upper_local_addr_oe, .lower_local_addr_i(lo_w), .lower_local_addr_o,
        .lower_local_addr_oe, .local_addr_valid_n_i(as_w),
        .local_addr_valid_n_o, .local_addr_valid_n_oe, .req_out_n,
        .grant_in_n, .mastership_taken_n, .transfer_done_n, .local_data_i,
        .bus_fault_n, .retry_hold_n, .bp_in_req, .bp_in_upper, .bp_in_lower,
        .bp_in_read, .bp_in_done, .bp_in_rdata, .bp_out_busy, .bp_ack_cycle,
        .bp_tm, .bp_atten_null, .ext_req, .reg_sel, .reg_upper, .reg_lower);
    local_proc_model local_proc_model_i (
        .ref_clk, .slow, .req_out_n, .mastership_taken_n, .as_w,
        .ctl_oe(local_addr_valid_n_oe), .up_w, .lo_w, .grant_in_n,
        .transfer_done_n, .local_data_i);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] exp_data(input logic [6:0] a);
        return {a, 1'b0} ^ 8'hA5;
    endfunction
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // wait for the local cycle to end, then look at what it left
    task finish_access;
        int k;
        k = 0;
        while (bp_in_done !== 1'b1 && k < 300) begin
            step(1);
            k++;
        end
        if (k == 300) mismatches++;
        `CHECK("addr", a7, drv_a)
        `CHECK("taken", 1'b0, mastership_taken_n)
        if (bp_in_read) `CHECK("rdata", exp_data(a7), bp_in_rdata)
        bp_in_req = 1'b0;
        step(3);
        `CHECK("req_free", 1'b1, req_out_n)
        `CHECK("oe_free", 3'h0, oe3)
    endtask
    task start_access(input logic rd);
        bp_in_upper = 5'($urandom);
        bp_in_lower = 2'($urandom);
        bp_in_read = rd;
        bp_in_req = 1'b1;
    endtask
    // processor strobes only over a valid address
    task proc_on;
        p_up = 5'($urandom);
        p_lo = 2'($urandom);
        p_drv = 1'b1;
        step(1);
        p_as_n = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // clock, watchdog, sequence
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) pat <= pat + 8'h1D;
    initial begin
        #50000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        {rstn, slow, p_drv, p_up, p_lo, bp_in_req, bp_in_read} = '0;
        {bp_in_upper, bp_in_lower, bp_out_busy, bp_ack_cycle} = '0;
        {bp_tm, bp_atten_null, ext_req, pat, mismatches, check_count} = '0;
        p_as_n = 1'b1;
        void'($urandom(55));
        step(5);
        `CHECK("rst", 4'hF, idle4)
        rstn = 1'b1;
        step(1);
        // local reads and one write, random pace
        for (int i = 0; i < 6; i++) begin
            slow = 1'($urandom);
            start_access(i != 3);
            finish_access;
        end
        // every transfer mode code during the ack cycle
        for (int t = 0; t < 4; t++) begin
            proc_on;
            step(4);
            `CHECK("reg_sel", 1'b1, reg_sel)
            `CHECK("reg_addr", {p_up, p_lo}, {reg_upper, reg_lower})
            bp_out_busy = 1'b1;
            bp_tm = 2'(t);
            bp_ack_cycle = 1'b1;
            step(1);
            bp_ack_cycle = 1'b0;
            step(1);
            `CHECK("fault", 1'(t == 0), bus_fault_n)
            `CHECK("no_retry", 1'b1, retry_hold_n)
            p_as_n = 1'b1;
            step(1);
            {p_drv, bp_out_busy} = '0;
            step(12);
            `CHECK("fault_free", 1'b1, bus_fault_n)
        end
        // incoming access meets an outgoing one
        proc_on;
        bp_out_busy = 1'b1;
        start_access(1'b1);
        step(2);
        `CHECK("col_fault", 1'b0, bus_fault_n)
        `CHECK("col_retry", 1'b0, retry_hold_n)
        p_as_n = 1'b1;
        step(1);
        {p_drv, bp_out_busy} = '0;
        finish_access;
        step(12);
        `CHECK("col_free", 1'b1, bus_fault_n)
        `CHECK("retry_held", 1'b0, retry_hold_n)
        bp_atten_null = 1'b1;
        step(1);
        bp_atten_null = 1'b0;
        step(2);
        `CHECK("retry_free", 1'b1, retry_hold_n)
        // external master asks for the bus
        ext_req = 1'b1;
        step(3);
        `CHECK("ext_req", 1'b0, req_out_n)
        ext_req = 1'b0;
        step(10);
        report_and_stop;
    end
endmodule // local_bus_master_handoff_tb
